// >>> hw/adr_clk_sync.sv
// Quarter-rate divider, reference alignment, phase latch and data-clock reset.
// Assumes pin inputs are asynchronous to pclk; controls arrive from flops.
`timescale 1ns/1ns
module adr_clk_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pce,
    // Pins
    input  wire logic reference_clock_in,
    input  wire logic data_clock_reset_in,
    output logic      reference_clock_out_a,
    output logic      reference_clock_out_b,
    output logic      ref_out_oe_n,
    // Register side
    adr_sync_if.core  sif
);
    import adr_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [1:0] ref_sync_q;
    logic [1:0] rst_sync_q;
    logic       ref_prev_q;
    logic       ref_rise;
    logic       data_clock_reset_in_now;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync_q <= 2'b00;
            rst_sync_q <= 2'b00;
            ref_prev_q <= 1'b0;
        end else if (pce) begin
            ref_sync_q <= {ref_sync_q[0], reference_clock_in};
            rst_sync_q <= {rst_sync_q[0], data_clock_reset_in};
            ref_prev_q <= ref_sync_q[1];
        end
    end

    assign ref_rise     = ref_sync_q[1] & ~ref_prev_q;
    assign data_clock_reset_in_now = sif.dclk_reset_enable & rst_sync_q[1];

    // ==========================================================
    // Divider, aligned to the reference edge in slave role
    logic [1:0] div_q;
    logic       aligned_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q     <= 2'b00;
            aligned_q <= 1'b0;
        end else if (pce) begin
            if (data_clock_reset_in_now) begin
                div_q     <= 2'b00;
                aligned_q <= 1'b0;
            end else if (sif.role == ADR_ROLE_SLAVE && ref_rise) begin
                div_q     <= 2'b01;
                aligned_q <= 1'b1;
            end else begin
                div_q     <= div_q + 2'b01;
                aligned_q <= aligned_q & (sif.role == ADR_ROLE_SLAVE);
            end
        end
    end

    // ==========================================================
    // Reference level latched at the selected phase
    logic ref_phase_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_phase_q <= 1'b0;
        end else if (pce && div_q == sif.phase_select) begin
            ref_phase_q <= ref_sync_q[1];
        end
    end

    // ==========================================================
    // Quarter-rate outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_clock_out_a <= 1'b0;
            reference_clock_out_b <= 1'b0;
            ref_out_oe_n          <= 1'b1;
        end else if (pce) begin
            reference_clock_out_a <= sif.ref_out_enable & div_q[1];
            reference_clock_out_b <= sif.ref_out_enable & div_q[1];
            ref_out_oe_n          <= ~sif.ref_out_enable;
        end
    end

    assign sif.div_phase         = div_q;
    assign sif.ref_phase_level   = ref_phase_q;
    assign sif.aligned           = aligned_q;
    assign sif.dclk_reset_active = data_clock_reset_in_now;

endmodule

// >>> hw/adr_pkg.sv
// Constants and types for the aperture delay and multi-chip sync register bank.
// Assumes a 32-bit APB slave; register indices map to byte address index*4.
package adr_pkg;

    // ==========================================================
    // Bus geometry
    localparam int unsigned ADR_DW = 32;
    localparam int unsigned ADR_AW = 8;
    localparam int unsigned ADR_RW = 16;

    // ==========================================================
    // Register indices, byte address is four times the index
    localparam logic [5:0] ADR_IDX_COARSE = 6'h0c;
    localparam logic [5:0] ADR_IDX_FINE   = 6'h0d;
    localparam logic [5:0] ADR_IDX_SYNC   = 6'h0e;
    localparam logic [5:0] ADR_IDX_RSVD   = 6'h0f;
    localparam logic [5:0] ADR_IDX_STATUS = 6'h10;

    // ==========================================================
    // Reset values
    localparam logic [15:0] ADR_RST_COARSE = 16'h0004;
    localparam logic [15:0] ADR_RST_FINE   = 16'h0000;
    localparam logic [15:0] ADR_RST_SYNC   = 16'h0003;
    localparam logic [15:0] ADR_RST_RSVD   = 16'h0018;

    // ==========================================================
    // Writable bit masks, reserved bits stay zero
    localparam logic [15:0] ADR_WMASK_COARSE = 16'hfffc;
    localparam logic [15:0] ADR_WMASK_FINE   = 16'hfc00;
    localparam logic [15:0] ADR_WMASK_SYNC   = 16'hff9f;

    // ==========================================================
    // Field positions
    localparam int unsigned ADR_COARSE_LSB = 4;
    localparam int unsigned ADR_COARSE_W   = 12;
    localparam int unsigned ADR_ADJ_EN_BIT = 3;
    localparam int unsigned ADR_DCC_BIT    = 2;
    localparam int unsigned ADR_FINE_LSB   = 10;
    localparam int unsigned ADR_FINE_W     = 6;
    localparam int unsigned ADR_REFD_LSB   = 7;
    localparam int unsigned ADR_REFD_W     = 9;
    localparam int unsigned ADR_PHASE_LSB  = 3;
    localparam int unsigned ADR_SLAVE_BIT  = 2;
    localparam int unsigned ADR_OUTDIS_BIT = 1;
    localparam int unsigned ADR_RSTDIS_BIT = 0;

    // ==========================================================
    // Saturation points of the delay codes
    localparam logic [11:0] ADR_COARSE_MAX = 12'h97f;
    localparam logic [8:0]  ADR_REFD_MAX   = 9'h13f;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ADR_PH_0   = 2'b00,
        ADR_PH_90  = 2'b01,
        ADR_PH_180 = 2'b10,
        ADR_PH_270 = 2'b11
    } adr_phase_t;

    typedef enum logic {
        ADR_ROLE_MASTER = 1'b0,
        ADR_ROLE_SLAVE  = 1'b1
    } adr_role_t;

endpackage

// >>> hw/adr_regs.sv
// Register bank for sample-clock aperture delay and multi-chip synchronisation.
// Assumes an APB master on pclk; pin inputs are asynchronous.
`timescale 1ns/1ns

// Notes on behaviour
// - Coarse code bits 15:4 sets delay; codes 2431 and above give maximum.
// - Coarse and fine codes act only while delay-adjust enable bit 3 is set.
// - Duty stabiliser on while coarse bit 2 is one; reset value is one.
// - Fine code bits 15:10 adds 0 to 63 steps, gated by delay-adjust enable.
// - Reference delay code bits 15:7; codes 319 and above give maximum.
// - Phase select bits 4:3 chooses 0, 90, 180 or 270 degree latch point.
// - Sync bit 2 set: slave, align divided clock to reference input.
// - Sync bit 1 clear: drive quarter-rate clock on both reference outputs.
// - Data-clock reset input ignored while sync bit 0 is one.
// - Reserved register (index 0Fh) is read-only, reads 0018h, writes ignored.
module adr_regs (
    // Clock, reset, enable
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       pce,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [adr_pkg::ADR_AW-1:0] paddr,
    input  wire logic [adr_pkg::ADR_DW-1:0] pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic      [adr_pkg::ADR_DW-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Pins
    input  wire logic                       reference_clock_in,
    input  wire logic                       data_clock_reset_in,
    output logic                            reference_clock_out_a,
    output logic                            reference_clock_out_b,
    output logic                            ref_out_oe_n,
    // Delay line controls
    output logic      [11:0]                coarse_delay_eff,
    output logic      [5:0]                 fine_delay_eff,
    output logic                            delay_adjust_enable,
    output logic                            duty_stabiliser_enable,
    output logic      [8:0]                 reference_delay_eff,
    output adr_pkg::adr_phase_t             phase_select,
    output logic                            slave_role_enable
);
    import adr_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [ADR_AW-1:0] byte_addr(input logic [5:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wdata,
                                          input logic [3:0]  strb,
                                          input logic [15:0] wmask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        merge = ((old & ~lanes) | (wdata & lanes)) & wmask;
    endfunction

    function automatic logic [11:0] sat12(input logic [11:0] code,
                                          input logic [11:0] lim);
        sat12 = (code > lim) ? lim : code;
    endfunction

    // ==========================================================
    // Address decode
    logic hit_coarse;
    logic hit_fine;
    logic hit_sync;
    logic hit_rsvd;
    logic hit_status;
    logic hit_any;
    logic setup_ph;
    logic access_ph;
    logic wr_en;

    assign hit_coarse = (paddr == byte_addr(ADR_IDX_COARSE));
    assign hit_fine   = (paddr == byte_addr(ADR_IDX_FINE));
    assign hit_sync   = (paddr == byte_addr(ADR_IDX_SYNC));
    assign hit_rsvd   = (paddr == byte_addr(ADR_IDX_RSVD));
    assign hit_status = (paddr == byte_addr(ADR_IDX_STATUS));
    assign hit_any    = hit_coarse | hit_fine | hit_sync | hit_rsvd | hit_status;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en     = access_ph & pwrite & pce;

    // Wait states while pce is low, plus one when a frozen setup cycle missed the read capture
    logic rd_ok_q;

    assign pready  = pce & (~access_ph | pwrite | rd_ok_q);
    assign pslverr = access_ph & ~hit_any;

    // ==========================================================
    // Writable registers
    logic [15:0] coarse_q;
    logic [15:0] fine_q;
    logic [15:0] sync_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_q <= ADR_RST_COARSE;
        end else if (wr_en && hit_coarse) begin
            coarse_q <= merge(coarse_q, pwdata[15:0], pstrb, ADR_WMASK_COARSE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_q <= ADR_RST_FINE;
        end else if (wr_en && hit_fine) begin
            fine_q <= merge(fine_q, pwdata[15:0], pstrb, ADR_WMASK_FINE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= ADR_RST_SYNC;
        end else if (wr_en && hit_sync) begin
            sync_q <= merge(sync_q, pwdata[15:0], pstrb, ADR_WMASK_SYNC);
        end
    end

    // ==========================================================
    // Field extraction
    logic [11:0] coarse_code;
    logic [5:0]  fine_code;
    logic [8:0]  refd_code;
    logic        adj_en;
    logic        dcc_en;
    logic        slave_bit;
    logic        outdis_bit;
    logic        rstdis_bit;
    adr_phase_t  phase_code;

    assign coarse_code = coarse_q[ADR_COARSE_LSB +: ADR_COARSE_W];
    assign fine_code   = fine_q[ADR_FINE_LSB +: ADR_FINE_W];
    assign refd_code   = sync_q[ADR_REFD_LSB +: ADR_REFD_W];
    assign adj_en      = coarse_q[ADR_ADJ_EN_BIT];
    assign dcc_en      = coarse_q[ADR_DCC_BIT];
    assign slave_bit   = sync_q[ADR_SLAVE_BIT];
    assign outdis_bit  = sync_q[ADR_OUTDIS_BIT];
    assign rstdis_bit  = sync_q[ADR_RSTDIS_BIT];
    assign phase_code  = adr_phase_t'(sync_q[ADR_PHASE_LSB +: 2]);

    // ==========================================================
    // Delay line drive
    logic [11:0] refd_wide;

    assign refd_wide = sat12({3'b000, refd_code}, {3'b000, ADR_REFD_MAX});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse_delay_eff    <= 12'h000;
            fine_delay_eff      <= 6'h00;
            delay_adjust_enable <= 1'b0;
        end else if (pce) begin
            delay_adjust_enable <= adj_en;
            if (adj_en) begin
                coarse_delay_eff <= sat12(coarse_code, ADR_COARSE_MAX);
                fine_delay_eff   <= fine_code;
            end else begin
                coarse_delay_eff <= 12'h000;
                fine_delay_eff   <= 6'h00;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_stabiliser_enable <= 1'b1;
        end else if (pce) begin
            duty_stabiliser_enable <= dcc_en;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_delay_eff <= 9'h000;
            phase_select        <= ADR_PH_0;
            slave_role_enable   <= 1'b0;
        end else if (pce) begin
            reference_delay_eff <= refd_wide[8:0];
            phase_select        <= phase_code;
            slave_role_enable   <= slave_bit;
        end
    end

    // ==========================================================
    // Clock sync core
    adr_sync_if sif ();

    assign sif.role              = slave_bit ? ADR_ROLE_SLAVE : ADR_ROLE_MASTER;
    assign sif.phase_select      = phase_code;
    assign sif.ref_out_enable    = ~outdis_bit;
    assign sif.dclk_reset_enable = ~rstdis_bit;

    adr_clk_sync u_sync (
        .pclk                  (pclk),
        .presetn               (presetn),
        .pce                   (pce),
        .reference_clock_in    (reference_clock_in),
        .data_clock_reset_in   (data_clock_reset_in),
        .reference_clock_out_a (reference_clock_out_a),
        .reference_clock_out_b (reference_clock_out_b),
        .ref_out_oe_n          (ref_out_oe_n),
        .sif                   (sif)
    );

    // ==========================================================
    // Status word
    logic [15:0] status_w;

    assign status_w = {11'h000, sif.dclk_reset_active, sif.aligned,
                       sif.ref_phase_level, sif.div_phase};

    // ==========================================================
    // Read path, data captured in the setup cycle, or in the access cycle if the setup cycle was frozen
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        if (hit_coarse) begin
            rd_mux = coarse_q;
        end else if (hit_fine) begin
            rd_mux = fine_q;
        end else if (hit_sync) begin
            rd_mux = sync_q;
        end else if (hit_rsvd) begin
            rd_mux = ADR_RST_RSVD;
        end else if (hit_status) begin
            rd_mux = status_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (pce && !pwrite && (setup_ph || (access_ph && !rd_ok_q))) begin
            prdata <= {16'h0000, rd_mux};
        end
    end

    // Read data captured for the transfer in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ok_q <= 1'b0;
        end else if (pce) begin
            if (access_ph && pready) begin
                rd_ok_q <= 1'b0;
            end else if (psel && !pwrite) begin
                rd_ok_q <= 1'b1;
            end
        end
    end

endmodule

// >>> hw/adr_sync_if.sv
// Control and status bundle between the register bank and the clock sync core.
// Assumes both ends run on pclk.
`timescale 1ns/1ns
interface adr_sync_if;
    import adr_pkg::*;
    adr_role_t  role;
    adr_phase_t phase_select;
    logic       ref_out_enable;
    logic       dclk_reset_enable;
    logic [1:0] div_phase;
    logic       ref_phase_level;
    logic       aligned;
    logic       dclk_reset_active;

    modport ctrl (
        output role, phase_select, ref_out_enable, dclk_reset_enable,
        input  div_phase, ref_phase_level, aligned, dclk_reset_active
    );
    modport core (
        input  role, phase_select, ref_out_enable, dclk_reset_enable,
        output div_phase, ref_phase_level, aligned, dclk_reset_active
    );
endinterface

// >>> tb/adr_regs_checker.sv
// Concurrent checks on the port behaviour of the aperture delay register bank.
// Assumes a bind onto adr_regs; registered outputs lag a write by one enabled edge.
`timescale 1ns/1ns
module adr_regs_checker (
    // Clock, reset, enable
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                pce,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // Pins and controls
    input wire logic                reference_clock_out_a,
    input wire logic                reference_clock_out_b,
    input wire logic                ref_out_oe_n,
    input wire logic [11:0]         coarse_delay_eff,
    input wire logic [5:0]          fine_delay_eff,
    input wire logic                delay_adjust_enable,
    input wire logic                duty_stabiliser_enable,
    input wire logic [8:0]          reference_delay_eff,
    input wire adr_pkg::adr_phase_t phase_select,
    input wire logic                slave_role_enable
);
    import adr_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pwrite && pready;
    wire rd = psel && penable && !pwrite && pready;
    // ==========================================================
    // Properties
    property p_coarse;
        wr && paddr == 8'h30 ##1 pce |=> coarse_delay_eff == (!$past(pwdata[3], 2) ? 12'h0 :
            ($past(pwdata[15:4], 2) > 12'h97f ? 12'h97f : $past(pwdata[15:4], 2)));
    endproperty
    a_coarse: assert property (p_coarse)
        else $error("coarse delay does not follow code");
    property p_gate;
        !delay_adjust_enable |-> coarse_delay_eff == 12'h0 && fine_delay_eff == 6'h0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("delay applied while adjust disabled");
    property p_dcc;
        wr && paddr == 8'h30 ##1 pce |=> duty_stabiliser_enable == $past(pwdata[2], 2);
    endproperty
    a_dcc: assert property (p_dcc)
        else $error("stabiliser enable wrong");
    property p_fine;
        wr && paddr == 8'h34 ##1 pce |=> fine_delay_eff == (delay_adjust_enable ? $past(pwdata[15:10], 2) : 6'h0);
    endproperty
    a_fine: assert property (p_fine)
        else $error("fine delay wrong");
    property p_refd;
        wr && paddr == 8'h38 ##1 pce |=> reference_delay_eff ==
            ($past(pwdata[15:7], 2) > 9'h13f ? 9'h13f : $past(pwdata[15:7], 2));
    endproperty
    a_refd: assert property (p_refd)
        else $error("reference delay wrong");
    property p_phase;
        wr && paddr == 8'h38 ##1 pce |=> phase_select == $past(pwdata[4:3], 2);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase select wrong");
    property p_slave;
        wr && paddr == 8'h38 ##1 pce |=> slave_role_enable == $past(pwdata[2], 2);
    endproperty
    a_slave: assert property (p_slave)
        else $error("role wrong");
    property p_refout;
        reference_clock_out_a == reference_clock_out_b && (!ref_out_oe_n || !reference_clock_out_a);
    endproperty
    a_refout: assert property (p_refout)
        else $error("reference outputs wrong");
    property p_rsvd;
        rd && paddr == 8'h3c |-> prdata == 32'h18 && !pslverr;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved register read wrong");
    property p_hold;
        pce && !wr ##1 pce && !wr |=> $stable(slave_role_enable) && $stable(phase_select) && $stable(duty_stabiliser_enable);
    endproperty
    a_hold: assert property (p_hold)
        else $error("control changed without write");
    // ==========================================================
    // Coverage
    c_wr: cover property (wr && paddr == 8'h30);
    c_rsvd: cover property (rd && paddr == 8'h3c);
    c_err: cover property (psel && penable && pslverr);
    c_out: cover property ($fell(ref_out_oe_n));
endmodule

// >>> tb/aperture_delay_autosync_regs_test.sv
// Self-checking bench for the aperture delay and sync register bank.
// Assumes adr_pkg and adr_regs compiled first; the bench drives every port.
`timescale 1ns/1ns
module aperture_delay_autosync_regs_test;
    import adr_pkg::*;
    logic        pclk, presetn, pce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata;
    logic        reference_clock_in, data_clock_reset_in, reference_clock_out_a, reference_clock_out_b;
    logic        ref_out_oe_n, delay_adjust_enable, duty_stabiliser_enable, slave_role_enable;
    logic [11:0] coarse_delay_eff;
    logic [5:0]  fine_delay_eff;
    logic [8:0]  reference_delay_eff;
    adr_phase_t  phase_select;
    logic [2:0]  ref_div;
    int          error_cnt, n_tests;
    bit          hold;
    logic [32:0] exp_q[$], msk_q[$];
    logic [11:0] cl[4] = '{12'h0, 12'h97f, 12'h980, 12'hfff};
    logic [8:0]  rl[4] = '{9'h0, 9'h13e, 9'h13f, 9'h1ff};

    adr_regs u_dut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .reference_clock_in, .data_clock_reset_in, .reference_clock_out_a,
        .reference_clock_out_b, .ref_out_oe_n, .coarse_delay_eff, .fine_delay_eff, .delay_adjust_enable,
        .duty_stabiliser_enable, .reference_delay_eff, .phase_select, .slave_role_enable);

    // ==========================================================
    // Clock and free-running reference
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) ref_div <= ref_div + 3'd1;
    assign reference_clock_in = ref_div[2];

    // ==========================================================
    // Compare, bus and closing tasks
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m = 33'h1ffffffff, input bit more = 0);
        if (!hold) psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        penable <= 1'b0;
        hold = more;
        if (!more) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit more = 0);
        apb(1'b1, a, d, 33'h0, 33'h1ffffffff, more);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [32:0] m = 33'h1ffffffff);
        apb(1'b0, a, 32'h0, {1'b0, e}, m);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Result monitor
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
            check({pslverr, pwrite ? 32'h0 : prdata} & msk_q.pop_front(), exp_q.pop_front());
    end

    initial begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end

    // ==========================================================
    // Tests
    initial begin
        logic [11:0] c;
        logic [5:0]  f;
        logic [8:0]  r;
        logic [31:0] v;
        int          j;
        int          k;
        logic        pa;
        logic        pb;
        {presetn, pce, psel, penable, pwrite, hold} = 6'b010000;
        {paddr, pwdata, pstrb, data_clock_reset_in, ref_div} = '0;
        pstrb = 4'hf;
        void'($urandom(32'h9272c890));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h30, 32'h4);
        rd(8'h34, 32'h0);
        rd(8'h38, 32'h3);
        check(duty_stabiliser_enable, 1'b1);
        check(ref_out_oe_n, 1'b1);
        check(slave_role_enable, 1'b0);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            c = (i > 7) ? 12'($urandom) : cl[i / 2];
            v = {16'h0, c, i[0], i[1], 2'b00};
            wr(8'h30, v);
            repeat (2) @(posedge pclk);
            check(coarse_delay_eff, i[0] ? (c > 12'h97f ? 12'h97f : c) : 12'h0);
            check(delay_adjust_enable, i[0]);
            check(duty_stabiliser_enable, i[1]);
            rd(8'h30, v);
        end
        $display("test coarse delay done");
        for (int i = 0; i < 4; i++) begin
            f = (i == 1) ? 6'h3f : 6'($urandom);
            wr(8'h30, {27'h0, i[0], i[0], 3'b100});
            wr(8'h34, {16'h0, f, 10'h0});
            repeat (2) @(posedge pclk);
            check(fine_delay_eff, i[0] ? f : 6'h0);
            rd(8'h34, {16'h0, f, 10'h0});
        end
        $display("test fine delay done");
        for (int i = 0; i < 8; i++) begin
            r = (i == 7) ? 9'($urandom) : rl[i % 4];
            v = {16'h0, r, 2'b00, i[1:0], i[2], 2'b11};
            wr(8'h38, v, 1);
            rd(8'h38, v);
            check(phase_select, i[1:0]);
            check(slave_role_enable, i[2]);
            check(reference_delay_eff, r > 9'h13f ? 9'h13f : r);
        end
        rd(8'h40, 32'h8, 33'h8);
        $display("test sync fields done");
        wr(8'h38, 32'h1);
        repeat (2) @(posedge pclk);
        check(ref_out_oe_n, 1'b0);
        {j, k, pa, pb} = {32'd0, 32'd0, reference_clock_out_a, reference_clock_out_b};
        repeat (16) begin
            @(posedge pclk);
            j += int'(reference_clock_out_a !== pa);
            k += int'(reference_clock_out_b !== pb);
            {pa, pb} = {reference_clock_out_a, reference_clock_out_b};
        end
        check(j, 8);
        check(k, 8);
        wr(8'h38, 32'h3);
        repeat (2) @(posedge pclk);
        check({ref_out_oe_n, reference_clock_out_a, reference_clock_out_b}, 3'b100);
        $display("test reference outputs done");
        data_clock_reset_in <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(8'h40, 32'h0, 33'h10);
        wr(8'h38, 32'h2);
        repeat (4) @(posedge pclk);
        rd(8'h40, 32'h10, 33'h13);
        data_clock_reset_in <= 1'b0;
        $display("test data clock reset done");
        apb(1'b1, 8'h3c, 32'hffff, 33'h0, 33'h1ffffffff, 1);
        rd(8'h3c, 32'h18);
        apb(1'b0, 8'h44, 32'h0, 33'h100000000);
        apb(1'b1, 8'h31, 32'hffff, 33'h100000000);
        pce <= 1'b0;
        fork
            rd(8'h30, 32'h1c);
            begin
                repeat (3) @(posedge pclk);
                pce <= 1'b1;
            end
        join
        $display("test refusals and stall done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h38, 32'h3);
        rd(8'h30, 32'h4);
        $display("test second reset done");
        end_sim();
    end
endmodule

bind adr_regs adr_regs_checker u_chk (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .reference_clock_out_a, .reference_clock_out_b, .ref_out_oe_n,
    .coarse_delay_eff, .fine_delay_eff, .delay_adjust_enable, .duty_stabiliser_enable,
    .reference_delay_eff, .phase_select, .slave_role_enable);
